// [rtl/csc_defines.svh]
`ifndef CSC_DEFINES_SVH
`define CSC_DEFINES_SVH

// ************************************************************
// register addresses (external data space, reached by dptr)
// ************************************************************
`define CSC_ADDR_BROWNOUT_CONFIG     16'hFFC8
`define CSC_ADDR_CLOCK_CONTROL     16'hFFDE
// ************************************************************
// special function register addresses
// ************************************************************
`define CSC_SFR_TRIM        8'h96
`define CSC_SFR_AUX         8'hA2

// ************************************************************
// field positions
// ************************************************************
`define CSC_UCFG_DBL        7
`define CSC_UCFG_BOI_HI     5
`define CSC_UCFG_BOI_LO     3
`define CSC_TRIM_RC         7
`define CSC_TRIM_CLOCK_OUT_ENABLE      6
`define CSC_AUX_LP          7

// ************************************************************
// reset values
// ************************************************************
`define CSC_FOSC_RST        3'h0
`define CSC_TRIM_RST        6'h00
`define CSC_BOI_RST         3'h0

// ************************************************************
// source select codes
// ************************************************************
`define CSC_FOSC_XTAL_LO    3'h0
`define CSC_FOSC_XTAL_MED   3'h1
`define CSC_FOSC_XTAL_HI    3'h2
`define CSC_FOSC_RC         3'h3
`define CSC_FOSC_WDOSC      3'h4
`define CSC_FOSC_EXT        3'h7

// ************************************************************
// timing
// ************************************************************
`define CSC_SYS_MHZ         100
`define CSC_XTAL_OSC_CYC    11'h400
`define CSC_SHORT_OSC_CYC   11'h020
`define CSC_XTAL_EXTRA_US   60
`define CSC_RC_WAKE_US      200

`endif

// [rtl/csc_pkg.sv]
package csc_pkg;

    typedef enum logic [1:0] {
        CSC_WAKE_XTAL,
        CSC_WAKE_RC,
        CSC_WAKE_SHORT
    } csc_wake_t;

    typedef enum logic [1:0] {
        CSC_ST_INIT,
        CSC_ST_RUN,
        CSC_ST_WAKE
    } csc_phase_t;

    typedef struct packed {
        logic [15:0] addr;
        logic        via_dptr;
        logic        rd;
        logic        wr;
        logic [7:0]  wdata;
    } csc_xbus_t;

    typedef struct packed {
        logic [7:0] addr;
        logic       rd;
        logic       wr;
        logic [7:0] wdata;
    } csc_sfr_t;

endpackage

// [rtl/csc_wake_timer.sv]
`include "csc_defines.svh"

module csc_wake_timer import csc_pkg::*; #(
    parameter int XTAL_EXTRA_CYC = 6000,
    parameter int RC_WAKE_CYC    = 20000
) (
    input  wire logic      sys_clk,
    input  wire logic      sys_rst,
    input  wire logic      start,
    input  wire csc_wake_t kind,
    input  wire logic      osc_tick,
    output logic           busy,
    output logic           done
);

    typedef enum logic [1:0] {CSC_W_IDLE, CSC_W_OSC, CSC_W_TIME} csc_wph_t;
    typedef struct packed {
        csc_wph_t    ph;
        logic [10:0] osc_cnt;
        logic [14:0] time_cnt;
        logic        done;
    } csc_wst_t;

    csc_wst_t s_reg;
    csc_wst_t s_next;

    always_comb begin
        s_next = s_reg;
        s_next.done = 1'b0;
        if (start) begin
            // a new start restarts a run cut short by a reset
            s_next.osc_cnt  = (kind == CSC_WAKE_XTAL) ? `CSC_XTAL_OSC_CYC
                            : `CSC_SHORT_OSC_CYC;
            s_next.time_cnt = (kind == CSC_WAKE_XTAL)
                            ? 15'(XTAL_EXTRA_CYC)
                            : 15'(RC_WAKE_CYC);
            s_next.ph = (kind == CSC_WAKE_RC) ? CSC_W_TIME : CSC_W_OSC;
        end else begin
            unique case (s_reg.ph)
                CSC_W_IDLE: begin
                end
                CSC_W_OSC: if (osc_tick) begin
                    if (s_reg.osc_cnt == 11'h001) begin
                        if (kind == CSC_WAKE_XTAL) begin
                            s_next.ph = CSC_W_TIME;
                        end else begin
                            s_next.ph   = CSC_W_IDLE;
                            s_next.done = 1'b1;
                        end
                    end else begin
                        s_next.osc_cnt = s_reg.osc_cnt - 11'h001;
                    end
                end
                CSC_W_TIME: begin
                    if (s_reg.time_cnt <= 15'h0001) begin
                        s_next.ph   = CSC_W_IDLE;
                        s_next.done = 1'b1;
                    end else begin
                        s_next.time_cnt = s_reg.time_cnt - 15'h0001;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_reg <= '{CSC_W_IDLE, 11'h000, 15'h0000, 1'b0};
        end else begin
            s_reg <= s_next;
        end
    end

    assign busy = (s_reg.ph != CSC_W_IDLE);
    assign done = s_reg.done;

    a_rc_no_osc: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (s_reg.ph == CSC_W_IDLE && start && kind == CSC_WAKE_RC)
        |=> busy [*2]) else $error("rc wake ended too early");

endmodule

// [rtl/csc_clk_gate.sv]
module csc_clk_gate (
    input  wire logic sys_clk,
    input  wire logic sys_rst,
    input  wire logic osc_tick,
    input  wire logic gate_open,
    input  wire logic clock_out_pin_en,
    output logic      cpu_tick,
    output logic      pclk_tick,
    output logic      clock_out_pin_level
);

    typedef struct packed {
        logic cpu;
        logic pclk;
        logic half;
        logic clock_out_pin;
    } csc_gst_t;

    csc_gst_t g_reg;
    csc_gst_t g_next;

    always_comb begin
        g_next = g_reg;
        // whole ticks only pass, so the gate never cuts a pulse
        g_next.cpu  = osc_tick & gate_open;
        g_next.pclk = g_next.cpu & g_reg.half;
        if (g_next.cpu) begin
            g_next.half = ~g_reg.half;
        end
        if (!clock_out_pin_en) begin
            g_next.clock_out_pin = 1'b0;
        end else if (g_next.cpu) begin
            g_next.clock_out_pin = ~g_reg.clock_out_pin;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            g_reg <= '{1'b0, 1'b0, 1'b0, 1'b0};
        end else begin
            g_reg <= g_next;
        end
    end

    assign cpu_tick     = g_reg.cpu;
    assign pclk_tick    = g_reg.pclk;
    assign clock_out_pin_level = g_reg.clock_out_pin;

    a_pclk_in_cpu: assert property (@(posedge sys_clk) disable iff (sys_rst)
        pclk_tick |-> cpu_tick && !$past(pclk_tick))
        else $error("peripheral tick not half rate");

    a_clock_out_pin_flip: assert property (@(posedge sys_clk) disable iff (sys_rst)
        (osc_tick && gate_open && clock_out_pin_en)
        |=> clock_out_pin_level != $past(clock_out_pin_level))
        else $error("clock out did not toggle");

endmodule

// [rtl/csc_top.sv]
// Notes on behaviour
// - clock control and brownout registers reached only by dptr external moves
// - power-on loads brownout bits from config 5:3
// - control register resets from config bits
// - machine cycle is two cpu clocks
// - oscillator clock chosen among four sources
// - peripheral clock is half cpu clock
// - rc oscillator nominal, doubler doubles it
// - trim reloads only on power-on or watchdog
// - clock out only when crystal unused
// - clock out toggles once per cpu clock
// - low power bit clears on reset
// - switch flag clears at start, sets done
// - crystal wake: 1024 cycles plus 60 us
// - rc wake lasts 200 to 300 us
// - watchdog or external wake: 32 cycles
// - watchdog oscillator rate 400 or 25 kHz
// - only low speed crystal may clock watchdog
`include "csc_defines.svh"

module csc_top import csc_pkg::*; #(
    parameter int XTAL_EXTRA_CYC = `CSC_XTAL_EXTRA_US * `CSC_SYS_MHZ,
    parameter int RC_WAKE_CYC    = `CSC_RC_WAKE_US * `CSC_SYS_MHZ
) (
    input  wire logic       sys_clk,
    input  wire logic       sys_rst,
    input  wire logic       soft_rst,
    input  wire logic       soft_rst_wdt,
    input  wire logic [7:0] user_config_byte1,
    input  wire logic [5:0] trim_factory,
    input  wire csc_xbus_t  xbus,
    output logic      [7:0] xd_rdata,
    input  wire csc_sfr_t   sfr,
    output logic      [7:0] sfr_rdata,
    input  wire logic       xtal_tick,
    input  wire logic       rc_tick,
    input  wire logic       wdosc_tick,
    input  wire logic       ext_tick,
    input  wire logic       rtc_uses_xtal,
    output logic            osc_clock,
    output logic            cpu_clock,
    output logic            pclk_tick,
    output logic            clock_out_pin_o,
    output logic            clock_out_pin_oe,
    output logic      [2:0] osc_src,
    output logic      [5:0] rc_trim,
    output logic            rc_doubler_bit,
    output logic            wdosc_slow,
    output logic            crystal_to_watchdog,
    output logic            low_power_clock_bit,
    output logic      [2:0] brownout_int_cfg,
    output logic            switch_done_flag
);

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        csc_phase_t phase;
        logic       por_pending;
        logic       trim_pending;
        logic       switch_done_flag;
        logic       watchdog_mode_bit;
        logic       xtal_wd_bit;
        logic       rc_doubler_bit;
        logic [2:0] fosc_req;
        logic [2:0] fosc_act;
        logic [2:0] boicfg;
        logic [5:0] trim;
        logic       trim_rc;
        logic       clock_out_enable;
        logic       low_power_clock_bit;
        logic       gate_open;
        logic       wake_start;
        logic [7:0] xd_rdata;
        logic [7:0] sfr_rdata;
    } csc_state_t;

    csc_state_t s_reg;
    csc_state_t s_next;

    logic       wake_busy;
    logic       wake_done;
    logic       req_tick;
    logic       xtal_in_use;
    logic       clock_out_pin_en;
    logic       clock_out_pin_level;
    logic       wr_clock_control;
    logic       wr_brownout_config;
    logic       rd_clock_control;
    logic       rd_brownout_config;
    csc_wake_t  wake_kind;
    logic [7:0] clock_control_view;

    // ************************************************************
    // source helpers
    // ************************************************************
    function automatic logic is_xtal(input logic [2:0] f);
        is_xtal = (f == `CSC_FOSC_XTAL_LO) || (f == `CSC_FOSC_XTAL_MED)
               || (f == `CSC_FOSC_XTAL_HI);
    endfunction

    function automatic csc_wake_t kind_of(input logic [2:0] f);
        if (is_xtal(f)) begin
            kind_of = CSC_WAKE_XTAL;
        end else if (f == `CSC_FOSC_WDOSC || f == `CSC_FOSC_EXT) begin
            kind_of = CSC_WAKE_SHORT;
        end else begin
            kind_of = CSC_WAKE_RC;
        end
    endfunction

    function automatic logic tick_of(input logic [2:0] f,
                                     input logic       xt,
                                     input logic       rc,
                                     input logic       wd,
                                     input logic       ex);
        if (is_xtal(f)) begin
            tick_of = xt;
        end else if (f == `CSC_FOSC_WDOSC) begin
            tick_of = wd;
        end else if (f == `CSC_FOSC_EXT) begin
            tick_of = ex;
        end else begin
            tick_of = rc;
        end
    endfunction

    // ************************************************************
    // register decode
    // ************************************************************
    // only the dptr form of the external move reaches these
    assign wr_clock_control = xbus.wr && xbus.via_dptr
                    && xbus.addr == `CSC_ADDR_CLOCK_CONTROL;
    assign wr_brownout_config = xbus.wr && xbus.via_dptr
                    && xbus.addr == `CSC_ADDR_BROWNOUT_CONFIG;
    assign rd_clock_control = xbus.rd && xbus.via_dptr
                    && xbus.addr == `CSC_ADDR_CLOCK_CONTROL;
    assign rd_brownout_config = xbus.rd && xbus.via_dptr
                    && xbus.addr == `CSC_ADDR_BROWNOUT_CONFIG;

    assign clock_control_view = {s_reg.switch_done_flag, 1'b0,
                          s_reg.watchdog_mode_bit, s_reg.xtal_wd_bit,
                          s_reg.rc_doubler_bit, s_reg.fosc_req};

    assign wake_kind = kind_of(s_reg.fosc_req);
    assign req_tick  = tick_of(s_reg.fosc_req, xtal_tick, rc_tick,
                               wdosc_tick, ext_tick);

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        s_next = s_reg;
        s_next.wake_start = 1'b0;
        if (xbus.rd) begin
            s_next.xd_rdata = rd_clock_control ? clock_control_view
                            : rd_brownout_config ? {5'h00, s_reg.boicfg} : 8'h00;
        end
        if (sfr.rd) begin
            s_next.sfr_rdata = 8'h00;
            if (sfr.addr == `CSC_SFR_TRIM) begin
                s_next.sfr_rdata = {s_reg.trim_rc, s_reg.clock_out_enable,
                                    s_reg.trim};
            end else if (sfr.addr == `CSC_SFR_AUX) begin
                s_next.sfr_rdata = {s_reg.low_power_clock_bit, 7'h00};
            end
        end
        unique case (s_reg.phase)
            CSC_ST_INIT: begin
                s_next.fosc_req = user_config_byte1[2:0];
                s_next.fosc_act = user_config_byte1[2:0];
                s_next.rc_doubler_bit = user_config_byte1[`CSC_UCFG_DBL];
                s_next.switch_done_flag  = 1'b1;
                s_next.watchdog_mode_bit = 1'b0;
                s_next.xtal_wd_bit       = 1'b0;
                s_next.low_power_clock_bit = 1'b0;
                if (s_reg.por_pending) begin
                    s_next.boicfg = user_config_byte1[`CSC_UCFG_BOI_HI:`CSC_UCFG_BOI_LO];
                end
                if (s_reg.trim_pending) begin
                    s_next.trim    = trim_factory;
                    s_next.trim_rc = 1'b0;
                    s_next.clock_out_enable = 1'b0;
                end
                s_next.por_pending  = 1'b0;
                s_next.trim_pending = 1'b0;
                s_next.gate_open    = 1'b0;
                s_next.wake_start   = 1'b1;
                s_next.phase        = CSC_ST_WAKE;
            end
            CSC_ST_RUN: begin
                // writes during a switch are refused
                if (wr_clock_control && s_reg.switch_done_flag) begin
                    s_next.watchdog_mode_bit = xbus.wdata[5];
                    s_next.xtal_wd_bit       = xbus.wdata[4];
                    s_next.rc_doubler_bit    = xbus.wdata[3];
                    s_next.fosc_req          = xbus.wdata[2:0];
                    if (xbus.wdata[2:0] != s_reg.fosc_act) begin
                        s_next.switch_done_flag = 1'b0;
                        s_next.gate_open  = 1'b0;
                        s_next.wake_start = 1'b1;
                        s_next.phase      = CSC_ST_WAKE;
                    end
                end
            end
            CSC_ST_WAKE: begin
                // a done left from a run that a reset cut short is ignored
                if (wake_done && !s_reg.wake_start) begin
                    s_next.fosc_act  = s_reg.fosc_req;
                    s_next.gate_open = 1'b1;
                    s_next.switch_done_flag = 1'b1;
                    s_next.phase = CSC_ST_RUN;
                end
            end
            default: s_next.phase = CSC_ST_INIT;
        endcase
        if (wr_brownout_config) begin
            s_next.boicfg = xbus.wdata[2:0];
        end
        if (sfr.wr && sfr.addr == `CSC_SFR_TRIM) begin
            s_next.trim    = sfr.wdata[5:0];
            s_next.trim_rc = sfr.wdata[`CSC_TRIM_RC];
            s_next.clock_out_enable = sfr.wdata[`CSC_TRIM_CLOCK_OUT_ENABLE];
        end
        if (sfr.wr && sfr.addr == `CSC_SFR_AUX) begin
            // software sets this only with the cpu clock at or below 8 MHz
            s_next.low_power_clock_bit = sfr.wdata[`CSC_AUX_LP];
        end
        // a later reset takes precedence over the phase, gate, low power bit and trim reload set above
        if (soft_rst) begin
            s_next.phase        = CSC_ST_INIT;
            s_next.gate_open    = 1'b0;
            s_next.low_power_clock_bit = 1'b0;
            s_next.trim_pending = soft_rst_wdt;
        end
    end

    // ************************************************************
    // state register
    // ************************************************************
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_reg <= '{CSC_ST_INIT, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0,
                       `CSC_FOSC_RST, `CSC_FOSC_RST, `CSC_BOI_RST,
                       `CSC_TRIM_RST, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0,
                       8'h00, 8'h00};
        end else begin
            s_reg <= s_next;
        end
    end

    // ************************************************************
    // wake delay and clock gate
    // ************************************************************
    csc_wake_timer #(
        .XTAL_EXTRA_CYC (XTAL_EXTRA_CYC),
        .RC_WAKE_CYC    (RC_WAKE_CYC)
    ) u_wake (
        .sys_clk  (sys_clk),
        .sys_rst  (sys_rst),
        .start    (s_reg.wake_start),
        .kind     (wake_kind),
        .osc_tick (req_tick),
        .busy     (wake_busy),
        .done     (wake_done)
    );

    assign osc_clock = tick_of(s_reg.fosc_act, xtal_tick, rc_tick,
                               wdosc_tick, ext_tick);

    assign crystal_to_watchdog = s_reg.xtal_wd_bit
                              && s_reg.fosc_act == `CSC_FOSC_XTAL_LO;
    assign xtal_in_use = is_xtal(s_reg.fosc_act) || rtc_uses_xtal
                      || crystal_to_watchdog;
    assign clock_out_pin_en   = s_reg.clock_out_enable && !xtal_in_use;

    csc_clk_gate u_gate (
        .sys_clk      (sys_clk),
        .sys_rst      (sys_rst),
        .osc_tick     (osc_clock),
        .gate_open    (s_reg.gate_open),
        .clock_out_pin_en    (clock_out_pin_en),
        .cpu_tick     (cpu_clock),
        .pclk_tick    (pclk_tick),
        .clock_out_pin_level (clock_out_pin_level)
    );

    // ************************************************************
    // outputs
    // ************************************************************
    assign clock_out_pin_o     = clock_out_pin_level;
    assign clock_out_pin_oe    = clock_out_pin_en;
    assign osc_src             = s_reg.fosc_act;
    assign rc_trim             = s_reg.trim;
    assign rc_doubler_bit      = s_reg.rc_doubler_bit;
    assign wdosc_slow          = s_reg.watchdog_mode_bit;
    assign low_power_clock_bit = s_reg.low_power_clock_bit;
    assign brownout_int_cfg    = s_reg.boicfg;
    assign switch_done_flag    = s_reg.switch_done_flag;
    assign xd_rdata            = s_reg.xd_rdata;
    assign sfr_rdata           = s_reg.sfr_rdata;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    a_no_dptr_ignored: assert property (
        (xbus.wr && !xbus.via_dptr && !soft_rst
         && !(sfr.wr) && s_reg.phase != CSC_ST_INIT)
        |=> $stable(brownout_int_cfg)) else $error("write without dptr");

    a_por_bod_load: assert property (
        (s_reg.phase == CSC_ST_INIT && s_reg.por_pending && !wr_brownout_config
         && !soft_rst)
        |=> brownout_int_cfg == $past(user_config_byte1[5:3]))
        else $error("brownout bits not loaded");

    a_ctrl_reset_val: assert property (
        (s_reg.phase == CSC_ST_INIT && !soft_rst)
        |=> clock_control_view == {4'h8, $past(user_config_byte1[7]), $past(user_config_byte1[2:0])})
        else $error("control register reset value");

    a_trim_kept: assert property (
        (soft_rst && !soft_rst_wdt && !sfr.wr) ##1 !sfr.wr
        |=> rc_trim == $past(rc_trim, 2)) else $error("trim changed");

    a_lp_cleared: assert property (
        soft_rst |=> !low_power_clock_bit) else $error("low power kept");

    a_switch_clear: assert property (
        (s_reg.phase == CSC_ST_RUN && wr_clock_control && switch_done_flag
         && xbus.wdata[2:0] != osc_src && !soft_rst)
        |=> !switch_done_flag ##1 wake_busy)
        else $error("switch flag not cleared");

    a_switch_set: assert property (
        (s_reg.phase == CSC_ST_WAKE && wake_done && !soft_rst
         && !s_reg.wake_start)
        |=> switch_done_flag && osc_src == $past(s_reg.fosc_req))
        else $error("switch completion missing");

    a_gate_closed: assert property (
        (s_reg.phase == CSC_ST_WAKE && !s_reg.gate_open)
        |=> !cpu_clock) else $error("cpu clock during wake");

    a_clock_out_pin_off: assert property (
        clock_out_pin_oe |-> !is_xtal(osc_src) && !rtc_uses_xtal)
        else $error("clock out with crystal in use");

    a_wdt_xtal: assert property (
        crystal_to_watchdog |-> osc_src == `CSC_FOSC_XTAL_LO)
        else $error("watchdog on fast crystal");

endmodule

// [verif/csc_osc_model.sv]
module csc_osc_model #(
    parameter int XT = 7,
    parameter int RC = 5,
    parameter int WD = 11,
    parameter int EX = 3
) (
    input  wire logic sys_clk,
    output logic      xtal_tick,
    output logic      rc_tick,
    output logic      wdosc_tick,
    output logic      ext_tick
);
    timeunit 1ns;
    timeprecision 1ps;
    int c = 0;
    initial {xtal_tick, rc_tick, wdosc_tick, ext_tick} = 4'h0;
    // one pulse a period from each free running source
    always @(posedge sys_clk) begin
        c          <= c + 1;
        xtal_tick  <= (c % XT) == 0;
        rc_tick    <= (c % RC) == 0;
        wdosc_tick <= (c % WD) == 0;
        ext_tick   <= (c % EX) == 0;
    end
endmodule

// [verif/testbench.sv]
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import csc_pkg::*;
    logic sys_clk = 0, sys_rst = 1, soft_rst = 0, soft_rst_wdt = 0, rtc_x = 0;
    logic [7:0] user_config_byte1 = 8'hAB, xd_rdata, srd, exp_q[$];
    logic dbl, wds, c2w, oc;
    time t0;
    logic [5:0] trim_factory = 6'h2A, rc_trim;
    logic [2:0] osc_src, boi;
    logic xt, rc, wd, ex, cpu, pclk, co_o, co_oe, lp, flag, rd_d = 0, prev;
    csc_xbus_t xbus = '0;
    csc_sfr_t sfr = '0;
    int err_count = 0, n_tests = 0, n, cc, pc, tg;
    logic [31:0] seed = 32'h3C7B1870;
    function automatic logic [31:0] xs();
        seed ^= seed << 13; seed ^= seed >> 17; seed ^= seed << 5;
        return seed;
    endfunction
    csc_osc_model u_osc (.sys_clk(sys_clk), .xtal_tick(xt), .rc_tick(rc),
        .wdosc_tick(wd), .ext_tick(ex));
    csc_top #(.XTAL_EXTRA_CYC(20), .RC_WAKE_CYC(30)) u_dut (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .soft_rst(soft_rst),
        .soft_rst_wdt(soft_rst_wdt), .user_config_byte1(user_config_byte1), .trim_factory(trim_factory),
        .xbus(xbus), .xd_rdata(xd_rdata), .sfr(sfr), .sfr_rdata(srd),
        .xtal_tick(xt), .rc_tick(rc), .wdosc_tick(wd), .ext_tick(ex),
        .rtc_uses_xtal(rtc_x), .osc_clock(oc), .cpu_clock(cpu),
        .pclk_tick(pclk),
        .clock_out_pin_o(co_o), .clock_out_pin_oe(co_oe), .osc_src(osc_src),
        .rc_trim(rc_trim), .rc_doubler_bit(dbl), .wdosc_slow(wds),
        .crystal_to_watchdog(c2w), .low_power_clock_bit(lp),
        .brownout_int_cfg(boi), .switch_done_flag(flag));
    initial forever #5 sys_clk = ~sys_clk;
    task chk(input logic [7:0] got, input logic [7:0] e);
        n_tests++;
        if (got !== e) begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, e);
        end
    endtask
    task xacc(input bit w, input logic [15:0] a, input logic [7:0] d, e);
        @(negedge sys_clk) xbus <= '{a, 1'b1, !w, w, d};
        if (!w) exp_q.push_back(e);
        @(negedge sys_clk) xbus <= '0;
    endtask
    task sfr_wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk) sfr <= '{a, 1'b0, 1'b1, d};
        @(negedge sys_clk) sfr <= '0;
    endtask
    task srst(input logic w);
        @(negedge sys_clk) {soft_rst, soft_rst_wdt} <= {1'b1, w};
        @(negedge sys_clk) soft_rst <= 0;
        repeat (2) @(negedge sys_clk);
    endtask
    task test_done();
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge sys_clk) rd_d <= xbus.rd & xbus.via_dptr;
    always @(negedge sys_clk) if (rd_d) chk(xd_rdata, exp_q.pop_front());
    initial begin
        #200000 err_count++;
        test_done();
    end
    initial begin
        // doubler on, and config bits 5:3 load brownout value 5
        repeat (12) @(posedge sys_clk);
        @(negedge sys_clk) sys_rst = 0;
        t0 = $time;
        repeat (2) @(negedge sys_clk);
        chk({2'h0, rc_trim}, 8'h2A);
        chk({5'h00, boi}, 8'h05);
        chk({7'h0, dbl}, 8'h01);
        xacc(0, 16'hFFDE, 8'h00, 8'h8B);
        xacc(0, 16'hFFC8, 8'h00, 8'h05);
        xacc(0, 16'hFFCB, 8'h00, 8'h00);
        // a write without the data pointer form must be ignored
        @(negedge sys_clk) xbus <= '{16'hFFC8, 1'b0, 1'b0, 1'b1, 8'h02};
        @(negedge sys_clk) xbus <= '0;
        xacc(0, 16'hFFC8, 8'h00, 8'h05);
        xacc(1, 16'hFFC8, 8'h02, 8'h00);
        chk({5'h00, boi}, 8'h02);
        for (n = 0; n < 500 && cpu !== 1'b1; n++) @(negedge sys_clk);
        // rc wake of 30 to 45 cycles counted from reset release
        tg = ($time - t0) / 10;
        chk({7'h0, tg inside {[30:45]}}, 8'h01);
        // doubler off keeps the rc clock below 8 MHz for the low power bit
        xacc(1, 16'hFFDE, 8'h33, 8'h00);
        chk({5'h00, dbl, wds, c2w}, 8'h02);
        sfr_wr(8'h96, 8'h6A);
        sfr_wr(8'hA2, 8'h80);
        @(negedge sys_clk) sfr <= '{8'h96, 1'b1, 1'b0, 8'h00};
        @(negedge sys_clk) sfr <= '0;
        chk(srd, 8'h6A);
        chk({co_oe, lp}, 8'h03);
        {cc, pc, tg, prev} = '0;
        repeat (300) begin
            @(negedge sys_clk);
            cc += cpu; pc += pclk; tg += (co_o !== prev); prev = co_o;
            chk({7'h0, oc}, {7'h0, rc});
        end
        chk({7'h0, (cc - 2 * pc) inside {[-2:2]}}, 8'h01);
        chk({7'h0, (cc - tg) inside {[-1:1]} && cc > 10}, 8'h01);
        rtc_x = 1'b1;
        @(negedge sys_clk) chk({7'h0, co_oe}, 8'h00);
        rtc_x = xs() % 2 == 0;
        @(negedge sys_clk) chk({7'h0, co_oe}, {7'h0, !rtc_x});
        while (flag !== 1'b1) @(negedge sys_clk);
        xacc(1, 16'hFFDE, 8'h0F, 8'h00);
        chk({7'h0, flag}, 8'h00);
        for (n = 0; n < 400 && flag !== 1'b1; n++) @(negedge sys_clk);
        chk({7'h0, n >= 90 && n <= 110}, 8'h01);
        chk({5'h00, osc_src}, 8'h07);
        xacc(0, 16'hFFDE, 8'h00, 8'h8F);
        // low speed crystal: 1024 ticks of 7 cycles plus 20 cycles
        xacc(1, 16'hFFDE, 8'h00, 8'h00);
        for (n = 0; n < 8000 && flag !== 1'b1; n++) @(negedge sys_clk);
        chk({7'h0, n inside {[7168:7228]}}, 8'h01);
        chk({4'h0, co_oe, osc_src}, 8'h00);
        trim_factory = xs() % 64;
        srst(0);
        chk({lp, rc_trim}, 8'h2A);
        srst(1);
        chk({2'h0, rc_trim}, {2'h0, trim_factory});
        repeat (4) @(negedge sys_clk);
        test_done();
    end
endmodule
